// ===== sfs_deglitch.sv
`timescale 1ns/100ps
`default_nettype none
module sfs_deglitch
    import sfs_pkg::*;
#(
    parameter int COUNT = SFS_UVOV_DGL_CYC
)(
    input wire logic clk_i,
    input wire logic reset_i,
    sfs_dgl_if.filt dgl
);
    logic [SFS_DGL_W-1:0] cnt_reg;
    logic [SFS_DGL_W-1:0] cnt_next;
    localparam logic [SFS_DGL_W-1:0] LIMIT = SFS_DGL_W'(COUNT);

    // Counter restarts on any drop, saturates at the limit
    always_comb
    begin
        if (!dgl.raw)
            cnt_next = '0;
        else if (cnt_reg == LIMIT)
            cnt_next = cnt_reg;
        else
            cnt_next = cnt_reg + SFS_DGL_W'(1);
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    assign dgl.hit = (cnt_reg == LIMIT);

    property p_drop_clears;
        @(posedge clk_i) disable iff (reset_i) !dgl.raw |=> !dgl.hit;
    endproperty
    a_drop_clears: assert property (p_drop_clears) else $error("filter hit after drop");

    property p_hit_needs_run;
        @(posedge clk_i) disable iff (reset_i) $rose(dgl.hit) |-> $past(dgl.raw, 2) && $past(dgl.raw);
    endproperty
    a_hit_needs_run: assert property (p_hit_needs_run) else $error("hit without steady input");
endmodule // sfs_deglitch
`default_nettype wire

// ===== sfs_dgl_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sfs_dgl_if;
    logic raw;
    logic hit;
    modport filt (input raw, output hit);
    modport user (output raw, input hit);
endinterface
`default_nettype wire

// ===== sfs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sfs_host_model
    import sfs_pkg::*;
(
    input wire logic clk_i,
    output logic [SFS_CHANNELS-1:0] on_write_o,
    output logic [SFS_CHANNELS-1:0] on_value_o,
    output logic quick_read_o,
    output logic device_read_o
);
    initial
    begin
        on_write_o = 5'h00;
        on_value_o = 5'h00;
        quick_read_o = 1'h0;
        device_read_o = 1'h0;
    end

    // One-cycle ON write; the value lines show garbage once the strobe is gone
    task automatic write_on(input logic [SFS_CHANNELS-1:0] mask,
                            input logic [SFS_CHANNELS-1:0] val);
        on_write_o = mask;
        on_value_o = val;
        @(posedge clk_i);
        #1;
        on_write_o = 5'h00;
        on_value_o = ~val;
    endtask

    // One-cycle status read; quick clears pump flag, device clears battery flags
    task automatic read_status(input logic quick);
        quick_read_o = quick;
        device_read_o = !quick;
        @(posedge clk_i);
        #1;
        quick_read_o = 1'h0;
        device_read_o = 1'h0;
    endtask
endmodule // sfs_host_model
`default_nettype wire

// ===== sfs_pkg.sv
package sfs_pkg;
    localparam int SFS_CHANNELS = 5;
    localparam int SFS_CLK_MHZ = 125;
    // Undervoltage and overvoltage deglitch, nominal figure
    localparam int SFS_UVOV_DGL_NS = 3500;
    localparam int SFS_UVOV_DGL_CYC = SFS_UVOV_DGL_NS * SFS_CLK_MHZ / 1000;
    // Charge pump deglitch, nominal figure
    localparam int SFS_CP_DGL_NS = 4000;
    localparam int SFS_CP_DGL_CYC = SFS_CP_DGL_NS * SFS_CLK_MHZ / 1000;
    localparam int SFS_DGL_W = 10;
    // Auto-restart in Fail mode: nominal 64 ms, window 48 to 80 ms
    localparam int SFS_RESTART_MS = 64;
    localparam int SFS_RESTART_CYC = SFS_RESTART_MS * SFS_CLK_MHZ * 1000;
    localparam int SFS_RESTART_W = 23;
    localparam logic SFS_FLAG_RST = 1'h0;
    localparam logic [SFS_CHANNELS-1:0] SFS_OUT_RST = 5'h00;
    // Synchroniser reset: pump bit reads bad, so power-up waits for a real good level
    localparam logic [2:0] SFS_SYNC_RST = 3'h4;
endpackage

// ===== sfs_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module sfs_supervisor
    import sfs_pkg::*;
#(
    parameter int RESTART_CYCLES = SFS_RESTART_CYC,
    parameter int UVOV_DGL_CYCLES = SFS_UVOV_DGL_CYC,
    parameter int CP_DGL_CYCLES = SFS_CP_DGL_CYC
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic battery_low_i,
    input wire logic battery_high_i,
    input wire logic pump_bad_i,
    input wire logic normal_mode_i,
    input wire logic [SFS_CHANNELS-1:0] on_write_i,
    input wire logic [SFS_CHANNELS-1:0] on_value_i,
    input wire logic quick_status_read_i,
    input wire logic device_status_read_i,
    output logic [SFS_CHANNELS-1:0] power_outputs_o,
    output logic [SFS_CHANNELS-1:0] high_overcurrent_window_o,
    output logic battery_low_flag_o,
    output logic battery_high_flag_o,
    output logic pump_failure_flag_o,
    output logic device_fault_summary_flag_o
);
    localparam logic [SFS_RESTART_W-1:0] RESTART_LAST = SFS_RESTART_W'(RESTART_CYCLES - 1);

    // Set wins over clear; a read clears only once the cause is gone
    function automatic logic latch_flag(input logic flag, input logic set,
                                        input logic rd, input logic cause);
        latch_flag = set | (flag & ~(rd & ~cause));
    endfunction

    // Two-stage synchronisers for the comparator pins
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            sync1_reg <= SFS_SYNC_RST;
            sync2_reg <= SFS_SYNC_RST;
        end
        else
        begin
            sync1_reg <= {pump_bad_i, battery_high_i, battery_low_i};
            sync2_reg <= sync1_reg;
        end
    end

    sfs_dgl_if uv_if ();
    sfs_dgl_if ov_if ();
    sfs_dgl_if cp_if ();
    assign uv_if.raw = sync2_reg[0];
    assign ov_if.raw = sync2_reg[1];
    assign cp_if.raw = sync2_reg[2];

    sfs_deglitch #(.COUNT(UVOV_DGL_CYCLES)) u_uv (.clk_i(clk_i), .reset_i(reset_i), .dgl(uv_if));
    sfs_deglitch #(.COUNT(UVOV_DGL_CYCLES)) u_ov (.clk_i(clk_i), .reset_i(reset_i), .dgl(ov_if));
    sfs_deglitch #(.COUNT(CP_DGL_CYCLES)) u_cp (.clk_i(clk_i), .reset_i(reset_i), .dgl(cp_if));

    logic uv_hit;
    logic ov_hit;
    logic cp_hit;
    assign uv_hit = uv_if.hit;
    assign ov_hit = ov_if.hit;
    assign cp_hit = cp_if.hit;

    logic [SFS_CHANNELS-1:0] cmd_on_reg;
    logic [SFS_CHANNELS-1:0] cmd_on_next;
    logic block_reg;
    logic block_next;
    logic settled_reg;
    logic settled_next;
    logic [SFS_RESTART_W-1:0] restart_cnt_reg;
    logic [SFS_RESTART_W-1:0] restart_cnt_next;
    logic [SFS_CHANNELS-1:0] out_reg;
    logic [SFS_CHANNELS-1:0] out_next;
    logic [SFS_CHANNELS-1:0] window_reg;
    logic [SFS_CHANNELS-1:0] window_next;
    logic low_flag_reg;
    logic low_flag_next;
    logic high_flag_reg;
    logic high_flag_next;
    logic pump_flag_reg;
    logic pump_flag_next;
    logic summary_reg;
    logic summary_next;
    logic host_on;
    logic enable;

    always_comb
    begin
        host_on = |(on_write_i & on_value_i);
        // Commands are always stored, so they wait out pump faults
        cmd_on_next = (cmd_on_reg & ~on_write_i) | (on_value_i & on_write_i);
        settled_next = settled_reg | ~sync2_reg[2];
        block_next = block_reg;
        restart_cnt_next = '0;
        if (uv_hit)
            block_next = 1'b1;
        else if (block_reg && normal_mode_i)
        begin
            if (host_on)
                block_next = 1'b0;
        end
        else if (block_reg)
        begin
            if (restart_cnt_reg == RESTART_LAST)
                block_next = 1'b0;
            else
                restart_cnt_next = restart_cnt_reg + SFS_RESTART_W'(1);
        end
        enable = settled_next && !block_next && !cp_hit && !uv_hit;
        out_next = enable ? cmd_on_next : SFS_OUT_RST;
        window_next = out_next & ~out_reg;
        low_flag_next = latch_flag(low_flag_reg, uv_hit, device_status_read_i, uv_hit);
        high_flag_next = latch_flag(high_flag_reg, ov_hit, device_status_read_i, ov_hit);
        pump_flag_next = latch_flag(pump_flag_reg, cp_hit, quick_status_read_i, cp_hit);
        summary_next = low_flag_next | high_flag_next | pump_flag_next;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cmd_on_reg <= SFS_OUT_RST;
            settled_reg <= 1'b0;
            block_reg <= 1'b0;
            restart_cnt_reg <= '0;
            out_reg <= SFS_OUT_RST;
            window_reg <= SFS_OUT_RST;
            low_flag_reg <= SFS_FLAG_RST;
            high_flag_reg <= SFS_FLAG_RST;
            pump_flag_reg <= SFS_FLAG_RST;
            summary_reg <= SFS_FLAG_RST;
        end
        else
        begin
            cmd_on_reg <= cmd_on_next;
            settled_reg <= settled_next;
            block_reg <= block_next;
            restart_cnt_reg <= restart_cnt_next;
            out_reg <= out_next;
            window_reg <= window_next;
            low_flag_reg <= low_flag_next;
            high_flag_reg <= high_flag_next;
            pump_flag_reg <= pump_flag_next;
            summary_reg <= summary_next;
        end
    end

    assign power_outputs_o = out_reg;
    assign high_overcurrent_window_o = window_reg;
    assign battery_low_flag_o = low_flag_reg;
    assign battery_high_flag_o = high_flag_reg;
    assign pump_failure_flag_o = pump_flag_reg;
    assign device_fault_summary_flag_o = summary_reg;

    property p_uv_off;
        @(posedge clk_i) disable iff (reset_i) uv_hit |=> out_reg == 5'h00;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("outputs on under undervoltage");

    property p_uv_flag;
        @(posedge clk_i) disable iff (reset_i) uv_hit |=> low_flag_reg && summary_reg;
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("battery low flag missing");

    property p_normal_hold;
        @(posedge clk_i) disable iff (reset_i)
            block_reg && normal_mode_i && !host_on |=> block_reg && out_reg == 5'h00;
    endproperty
    a_normal_hold: assert property (p_normal_hold) else $error("restart without host write");

    property p_flag_latched;
        @(posedge clk_i) disable iff (reset_i)
            (low_flag_reg && !device_status_read_i) || uv_hit |=> low_flag_reg;
    endproperty
    a_flag_latched: assert property (p_flag_latched) else $error("battery low flag dropped");

    property p_auto_restart;
        @(posedge clk_i) disable iff (reset_i)
            block_reg && !normal_mode_i && !uv_hit && restart_cnt_reg == RESTART_LAST
            |=> !block_reg;
    endproperty
    a_auto_restart: assert property (p_auto_restart) else $error("auto-restart missed");

    property p_ov_flag;
        @(posedge clk_i) disable iff (reset_i) ov_hit |=> high_flag_reg && summary_reg;
    endproperty
    a_ov_flag: assert property (p_ov_flag) else $error("battery high flag missing");

    property p_summary;
        @(posedge clk_i) disable iff (reset_i)
            summary_reg == (low_flag_reg | high_flag_reg | pump_flag_reg);
    endproperty
    a_summary: assert property (p_summary) else $error("summary flag mismatch");

    property p_unsettled_off;
        @(posedge clk_i) disable iff (reset_i) !settled_reg |-> out_reg == 5'h00;
    endproperty
    a_unsettled_off: assert property (p_unsettled_off) else $error("output on before pump settled");

    property p_cp_off;
        @(posedge clk_i) disable iff (reset_i) cp_hit |=> out_reg == 5'h00 && pump_flag_reg;
    endproperty
    a_cp_off: assert property (p_cp_off) else $error("pump failure not acted on");

    property p_pending_runs;
        @(posedge clk_i) disable iff (reset_i)
            cp_hit ##1 (!cp_hit && settled_reg && !block_reg && !uv_hit && on_write_i == 5'h00)
            |=> out_reg == cmd_on_reg && window_reg == cmd_on_reg;
    endproperty
    a_pending_runs: assert property (p_pending_runs) else $error("held command not run");

    property p_pump_latched;
        @(posedge clk_i) disable iff (reset_i)
            pump_flag_reg && (cp_hit || !quick_status_read_i) |=> pump_flag_reg;
    endproperty
    a_pump_latched: assert property (p_pump_latched) else $error("pump flag dropped");

    c_uv_shutdown: cover property (@(posedge clk_i) disable iff (reset_i) $rose(uv_hit) && out_reg != 5'h00);
    c_auto_restart: cover property (@(posedge clk_i) disable iff (reset_i) $fell(block_reg) && !normal_mode_i);
    c_cp_recover: cover property (@(posedge clk_i) disable iff (reset_i) $fell(cp_hit) ##1 window_reg != 5'h00);
    c_flag_clear: cover property (@(posedge clk_i) disable iff (reset_i) $fell(low_flag_reg));
endmodule // sfs_supervisor
`default_nettype wire

// ===== sfs_supervisor_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sfs_supervisor_tb
    import sfs_pkg::*;
;
    logic clk_i;
    logic reset_i;
    logic normal_mode_i;
    logic [2:0] pins;
    logic [SFS_CHANNELS-1:0] on_write, on_value, power_outputs_o, high_overcurrent_window_o;
    logic quick_read, device_read, low_f, high_f, pump_f, sum_f;
    logic [SFS_CHANNELS-1:0] flags;
    int failures = 0;
    int n_tests = 0;

    assign flags = {1'h0, sum_f, pump_f, high_f, low_f};
    initial clk_i = 1'h0;
    always #4 clk_i = ~clk_i;

    sfs_host_model i_sfs_host_model (.clk_i(clk_i), .on_write_o(on_write),
        .on_value_o(on_value), .quick_read_o(quick_read), .device_read_o(device_read));

    sfs_supervisor #(.RESTART_CYCLES(20), .UVOV_DGL_CYCLES(4), .CP_DGL_CYCLES(6))
    i_sfs_supervisor (.clk_i(clk_i), .reset_i(reset_i), .battery_low_i(pins[0]),
        .battery_high_i(pins[1]), .pump_bad_i(pins[2]), .normal_mode_i(normal_mode_i),
        .on_write_i(on_write), .on_value_i(on_value), .quick_status_read_i(quick_read),
        .device_status_read_i(device_read), .power_outputs_o(power_outputs_o),
        .high_overcurrent_window_o(high_overcurrent_window_o), .battery_low_flag_o(low_f),
        .battery_high_flag_o(high_f), .pump_failure_flag_o(pump_f),
        .device_fault_summary_flag_o(sum_f));

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    // Pins: bit 0 undervoltage, bit 1 overvoltage, bit 2 pump bad
    task automatic hold(input logic [2:0] p, input int n);
        pins = p;
        repeat (n) tick();
    endtask

    task automatic check(input logic [SFS_CHANNELS-1:0] seen,
                         input logic [SFS_CHANNELS-1:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits up to 40 cycles for the outputs to match exp, then checks the window pulse
    task automatic wait_out(input logic [SFS_CHANNELS-1:0] exp,
                            input logic [SFS_CHANNELS-1:0] win);
        int n;
        n = 0;
        while (power_outputs_o !== exp && n < 40)
        begin
            tick();
            n++;
        end
        check(power_outputs_o, exp);
        check(high_overcurrent_window_o, win);
        tick();
        check(high_overcurrent_window_o, 5'h00);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #40000;
        failures++;
        report_and_stop();
    end

    initial
    begin
        reset_i = 1'h1;
        normal_mode_i = 1'h1;
        hold(3'h4, 3);
        check(power_outputs_o, 5'h00);
        reset_i = 1'h0;
        i_sfs_host_model.write_on(5'h1f, 5'h1f);
        hold(3'h4, 2);
        check(power_outputs_o, 5'h00);
        pins = 3'h0;
        wait_out(5'h1f, 5'h1f);
        hold(3'h1, 3);
        hold(3'h0, 6);
        check(power_outputs_o, 5'h1f);
        check(flags, 5'h00);
        hold(3'h1, 10);
        check(power_outputs_o, 5'h00);
        check(flags, 5'h09);
        i_sfs_host_model.read_status(1'h0);
        tick();
        check(flags, 5'h09);
        hold(3'h0, 30);
        check(power_outputs_o, 5'h00);
        i_sfs_host_model.write_on(5'h01, 5'h00);
        hold(3'h0, 3);
        check(power_outputs_o, 5'h00);
        check(flags, 5'h09);
        i_sfs_host_model.read_status(1'h0);
        tick();
        check(flags, 5'h00);
        i_sfs_host_model.write_on(5'h1f, 5'h1f);
        wait_out(5'h1f, 5'h1f);
        hold(3'h2, 10);
        check(flags, 5'h0a);
        check(power_outputs_o, 5'h1f);
        hold(3'h0, 6);
        i_sfs_host_model.read_status(1'h0);
        tick();
        check(flags, 5'h00);
        hold(3'h4, 12);
        check(power_outputs_o, 5'h00);
        check(flags, 5'h0c);
        i_sfs_host_model.write_on(5'h1f, 5'h03);
        hold(3'h4, 2);
        check(power_outputs_o, 5'h00);
        i_sfs_host_model.read_status(1'h1);
        tick();
        check(flags, 5'h0c);
        pins = 3'h0;
        wait_out(5'h03, 5'h03);
        i_sfs_host_model.read_status(1'h0);
        tick();
        check(flags, 5'h0c);
        i_sfs_host_model.read_status(1'h1);
        tick();
        check(flags, 5'h00);
        normal_mode_i = 1'h0;
        hold(3'h1, 10);
        check(power_outputs_o, 5'h00);
        hold(3'h0, 10);
        check(power_outputs_o, 5'h00);
        wait_out(5'h03, 5'h03);
        report_and_stop();
    end
endmodule // sfs_supervisor_tb
`default_nettype wire
